// >>> pmt_defines.svh
// Constants for the program memory and table-read block
// Assumes inclusion by pmt_pkg and pmt_program_memory only
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

`define PMT_WORDS         8192
`define PMT_ADDR_W        13
`define PMT_DATA_W        16
`define PMT_PAGE_WORDS    256
`define PMT_RESET_VECTOR  13'h0000
`define PMT_LAST_PAGE     5'h1f
`define PMT_EE_WORDS      64
`define PMT_EE_ADDR_W     6
`define PMT_FRAME_BITS    6'h1f
`define PMT_BIT_RW        6'h00
`define PMT_BIT_SPACE     6'h01
`define PMT_BIT_ADDR_LAST 6'h0e
`define PMT_BIT_DATA_LAST 6'h1e

`endif

// >>> pmt_pkg.sv
// Types for the program memory and table-read block
// Assumes pmt_defines.svh sits in the include path
`include "pmt_defines.svh"

package pmt_pkg;

  // Table read request from the core
  typedef struct packed {
    logic       last_page;
    logic [7:0] high_ptr;
    logic [7:0] low_ptr;
  } pmt_tab_req_t;

  // Table read result to the core
  typedef struct packed {
    logic [7:0] low_byte;
    logic [7:0] high_byte;
  } pmt_tab_res_t;

  typedef enum logic [1:0] {
    PMT_TAB_IDLE,
    PMT_TAB_ADDR,
    PMT_TAB_DATA
  } pmt_tab_state_t;

endpackage : pmt_pkg

// >>> pmt_prog_model.sv
// Serial programmer model: 31-bit frames, clock stands still between frames
// Assumes the bench resolves the shared data pin
`timescale 1ns/1ps
`default_nettype none
module pmt_prog_model (
  output logic      ck_o,
  output logic      en_o,
  output logic      d_o,
  input  wire logic pin_i
);
  initial {ck_o, en_o, d_o} = 3'h0;
  // Read frames keep driving d_o after the address, toggling it every bit
  task automatic xfer(input logic [30:0] f, output logic [15:0] q);
    q = 16'h0000;
    en_o = 1'b1;
    #100;
    for (int i = 30; i >= 0; i--) begin
      d_o = (f[30] && i < 16) ? ~d_o : f[i];
      #62.5 ck_o = 1'b1;
      if (i < 16) q[i] = pin_i;
      #62.5 ck_o = 1'b0;
    end
    #100 en_o = 1'b0;
    #101;
  endtask : xfer
endmodule : pmt_prog_model
`default_nettype wire

// >>> pmt_program_memory.sv
// Flash program store with fetch port, two-cycle table read and serial link
// Assumes a core on sys_clk_i and a programmer or debug adapter on the pins
//
// What this block does
// R01: Program store holds 8K words of 16 bits, addressed by the counter.
// R02: After reset fetching starts at program address zero.
// R03: Table address comes from low pointer and high pointer or last page, not the counter.
// R04: Table read returns the word's low byte for the operand register.
// R05: Table read loads the word's high byte into the high-byte latch.
// R06: Basic table read uses low pointer as offset in high-pointer page.
// R07: A page spans 256 words; low pointer picks one of them.
// R08: High-byte latch is read-only; only a table read or a reset (clearing it to 00) changes it.
// R09: Every table read takes two instruction cycles.
// R10: Software should mask interrupts around shared main-line table reads.
// R11: Programming moves data both ways on one line, clocked by programmer.
// R12: Serial link reads and writes both program store and data store.
// R13: Board must not drive programming lines from other outputs meanwhile.
// R14: Debug link has one two-way data line and one input clock.
// R15: While debugging, other functions sharing the debug pins are inactive.
// R16: Debug pins still serve as programming data and clock lines.
// R17: Table address is 13 bits; high-pointer bits above range ignored.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defines.svh"

module pmt_program_memory
  import pmt_pkg::*;
#(
  parameter int ADDR_W   = `PMT_ADDR_W,
  parameter int DATA_W   = `PMT_DATA_W,
  parameter int EE_WORDS = `PMT_EE_WORDS
) (
  // Clock, reset, enable
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Instruction fetch
  input  wire logic               pc_load_i,
  input  wire logic [ADDR_W-1:0]  pc_target_i,
  input  wire logic               pc_step_i,
  output logic      [ADDR_W-1:0]  fetch_addr_o,
  output logic      [DATA_W-1:0]  instr_o,
  // Table read
  input  wire logic               tab_start_i,
  input  wire pmt_tab_req_t       tab_req_i,
  output logic                    tab_busy_o,
  output logic                    tab_done_o,
  output logic      [7:0]         tab_low_byte_o,
  output logic      [7:0]         table_high_byte_latch_o,
  // Serial link pins, shared by programming and debug
  input  wire logic               debug_mode_i,
  input  wire logic               prog_enable_i,
  input  wire logic               prog_serial_clock_i,
  input  wire logic               prog_serial_data_i,
  output logic                    prog_serial_data_o,
  output logic                    prog_serial_data_oe_o,
  output logic                    shared_func_en_o,
  output logic                    core_hold_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] prog_mem [`PMT_WORDS];  // R01
  logic [7:0]        ee_mem   [EE_WORDS];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       ck_prev_reg;
  wire  [3:0] pin_raw = {debug_mode_i, prog_enable_i, prog_serial_clock_i, prog_serial_data_i};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg   <= 4'h0;
      sync2_reg   <= 4'h0;
      ck_prev_reg <= 1'b0;
    end else if (ce_i) begin
      sync1_reg   <= pin_raw;
      sync2_reg   <= sync1_reg;
      ck_prev_reg <= sync2_reg[1];
    end
  end

  wire dbg_s     = sync2_reg[3];
  wire link_on   = sync2_reg[2];
  wire sck_s     = sync2_reg[1];
  wire sda_s     = sync2_reg[0];
  wire sck_rise  = link_on & sck_s & ~ck_prev_reg;  // R11 R16
  wire sck_fall  = link_on & ~sck_s & ck_prev_reg;

  // ----------------------------------------------------------------
  // Fetch counter
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic [DATA_W-1:0] instr_reg;

  assign pc_next = pc_load_i ? pc_target_i :
                   pc_step_i ? ADDR_W'(pc_reg + 1'b1) : pc_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_reg    <= `PMT_RESET_VECTOR;  // R02
      instr_reg <= '0;
    end else if (ce_i && !link_on) begin
      pc_reg    <= pc_next;
      instr_reg <= prog_mem[pc_next];  // R01
    end
  end

  // ----------------------------------------------------------------
  // Table read, two cycles
  // ----------------------------------------------------------------
  pmt_tab_state_t    tab_state_reg;
  pmt_tab_state_t    tab_state_next;
  logic [ADDR_W-1:0] tab_addr_reg;
  logic [7:0]        tab_low_reg;
  logic [7:0]        tab_high_reg;
  logic              tab_done_reg;
  logic              tab_busy_reg;

  wire [4:0] page_sel = tab_req_i.last_page ? `PMT_LAST_PAGE
                                            : tab_req_i.high_ptr[4:0];  // R06 R17
  wire [ADDR_W-1:0] tab_addr = {page_sel, tab_req_i.low_ptr};  // R03 R07
  wire [DATA_W-1:0] tab_word = prog_mem[tab_addr_reg];

  always_comb begin
    case (tab_state_reg)
      PMT_TAB_IDLE: tab_state_next = tab_start_i && !link_on ? PMT_TAB_ADDR : PMT_TAB_IDLE;
      PMT_TAB_ADDR: tab_state_next = PMT_TAB_DATA;  // R09
      PMT_TAB_DATA: tab_state_next = PMT_TAB_IDLE;
      default:      tab_state_next = PMT_TAB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tab_state_reg <= PMT_TAB_IDLE;
      tab_addr_reg  <= '0;
      tab_low_reg   <= 8'h00;
      tab_high_reg  <= 8'h00;
      tab_done_reg  <= 1'b0;
      tab_busy_reg  <= 1'b0;
    end else if (ce_i) begin
      tab_state_reg <= tab_state_next;
      tab_done_reg  <= (tab_state_reg == PMT_TAB_DATA);  // R09
      tab_busy_reg  <= (tab_state_next != PMT_TAB_IDLE);  // R09
      if (tab_state_reg == PMT_TAB_IDLE) begin
        tab_addr_reg <= tab_addr;  // R03
      end
      if (tab_state_reg == PMT_TAB_DATA) begin
        tab_low_reg  <= tab_word[7:0];   // R04
        tab_high_reg <= tab_word[15:8];  // R05 R08 R10
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  logic [5:0]        bit_cnt_reg;
  logic              rd_reg;
  logic              ee_sel_reg;
  logic [ADDR_W-1:0] sa_reg;
  logic [DATA_W-1:0] sd_reg;
  logic              sdo_reg;
  logic              sdoe_reg;

  wire in_data   = bit_cnt_reg > `PMT_BIT_ADDR_LAST;
  wire addr_done = sck_rise && bit_cnt_reg == `PMT_BIT_ADDR_LAST;
  wire data_done = sck_rise && bit_cnt_reg == `PMT_BIT_DATA_LAST;
  wire [ADDR_W-1:0] sa_full = {sa_reg[ADDR_W-2:0], sda_s};
  wire [DATA_W-1:0] sd_full = {sd_reg[DATA_W-2:0], sda_s};
  wire [`PMT_EE_ADDR_W-1:0] ee_idx = sa_full[`PMT_EE_ADDR_W-1:0];
  wire [DATA_W-1:0] rd_word = ee_sel_reg ? {8'h00, ee_mem[ee_idx]} : prog_mem[sa_full];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= 6'h00;
      rd_reg      <= 1'b0;
      ee_sel_reg  <= 1'b0;
      sa_reg      <= '0;
      sd_reg      <= '0;
      sdo_reg     <= 1'b0;
      sdoe_reg    <= 1'b0;
    end else if (ce_i) begin
      if (!link_on) begin
        bit_cnt_reg <= 6'h00;
        sdoe_reg    <= 1'b0;
      end else if (sck_rise) begin
        bit_cnt_reg <= (bit_cnt_reg == `PMT_BIT_DATA_LAST) ? 6'h00 : bit_cnt_reg + 6'h01;
        if (bit_cnt_reg == `PMT_BIT_RW) rd_reg <= sda_s;
        if (bit_cnt_reg == `PMT_BIT_SPACE) ee_sel_reg <= sda_s;  // R12
        if (!in_data && bit_cnt_reg > `PMT_BIT_SPACE) sa_reg <= sa_full;
        if (addr_done && rd_reg) sd_reg <= rd_word;  // R12
        else if (in_data) sd_reg <= rd_reg ? {sd_reg[DATA_W-2:0], 1'b0} : sd_full;
        if (data_done) sdoe_reg <= 1'b0;
      end else if (sck_fall && rd_reg && in_data) begin
        sdo_reg  <= sd_reg[DATA_W-1];  // R11 R14
        sdoe_reg <= 1'b1;
      end
    end
  end

  // Writes to either store at frame end
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && data_done && !rd_reg) begin
      if (ee_sel_reg) ee_mem[sa_reg[`PMT_EE_ADDR_W-1:0]] <= sd_full[7:0];  // R12
      else prog_mem[sa_reg] <= sd_full;  // R12
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic shared_en_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) shared_en_reg <= 1'b1;
    else if (ce_i) shared_en_reg <= ~dbg_s & ~link_on;  // R15 R13
  end

  assign fetch_addr_o            = pc_reg;
  assign instr_o                 = instr_reg;
  assign tab_busy_o              = tab_busy_reg;
  assign tab_done_o              = tab_done_reg;
  assign tab_low_byte_o          = tab_low_reg;
  assign table_high_byte_latch_o = tab_high_reg;
  assign prog_serial_data_o      = sdo_reg;
  assign prog_serial_data_oe_o   = sdoe_reg;
  assign shared_func_en_o        = shared_en_reg;
  assign core_hold_o             = sync2_reg[2];

endmodule : pmt_program_memory
`default_nettype wire

// >>> pmt_program_memory_asserts.sv
// Checker for table-read timing, fetch stepping and link ownership
// Assumes binding into pmt_program_memory
`timescale 1ns/1ps
`default_nettype none
module pmt_program_memory_chk #(parameter int ADDR_W = 13) (
  // Core side
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  input wire logic              ce_i,
  input wire logic              pc_load_i,
  input wire logic              pc_step_i,
  input wire logic [ADDR_W-1:0] fetch_addr_o,
  input wire logic              tab_start_i,
  input wire logic              tab_busy_o,
  input wire logic              tab_done_o,
  // Link side
  input wire logic              debug_mode_i,
  input wire logic              prog_enable_i,
  input wire logic              prog_serial_data_oe_o,
  input wire logic              shared_func_en_o,
  input wire logic              core_hold_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  tab_len_a: assert property (tab_start_i && !tab_busy_o && !core_hold_o && ce_i
    |=> tab_busy_o ##1 tab_busy_o ##1 (tab_done_o && !tab_busy_o)) else $error("bad length");
  done_pulse_a: assert property (tab_done_o && ce_i |=> !tab_done_o)
    else $error("done too long");
  busy_end_a: assert property ($fell(tab_busy_o) |-> tab_done_o)
    else $error("busy ended without done");
  pc_step_a: assert property (ce_i && !core_hold_o && pc_step_i && !pc_load_i
    |=> fetch_addr_o == $past(fetch_addr_o) + 1'b1) else $error("bad step");
  fetch_hold_a: assert property (core_hold_o |=> fetch_addr_o == $past(fetch_addr_o))
    else $error("fetch moved in frame");
  link_hold_a: assert property (prog_enable_i[*5] |-> core_hold_o)
    else $error("core not held");
  shared_off_a: assert property (debug_mode_i[*5] |-> !shared_func_en_o)
    else $error("shared pins active");
  oe_off_a: assert property ((!prog_enable_i)[*5] |-> !prog_serial_data_oe_o)
    else $error("pin driven outside frame");
  cover property (tab_done_o);
  cover property (prog_serial_data_oe_o);
  cover property (debug_mode_i && core_hold_o);
endmodule : pmt_program_memory_chk
bind pmt_program_memory pmt_program_memory_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_i,
  .rst_n_i, .ce_i, .pc_load_i, .pc_step_i, .fetch_addr_o, .tab_start_i, .tab_busy_o,
  .tab_done_o, .debug_mode_i, .prog_enable_i, .prog_serial_data_oe_o, .shared_func_en_o,
  .core_hold_o);
`default_nettype wire

// >>> program_memory_table_read_test.sv
// Bench: programs the store over the link, then checks table reads and fetch
// Assumes pmt_prog_model stands on the link pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module program_memory_table_read_test;
  import pmt_pkg::*;
  localparam logic [12:0] ADR [6] = '{13'h0000, 13'h0123, 13'h0124, 13'h1f05, 13'h1f06, 13'h0105};
  logic sys_clk_i = 0, rst_n_i = 0, ce_i = 1, pc_load_i = 0, pc_step_i = 0;
  logic tab_start_i = 0, debug_mode_i = 0, s_d;
  logic [12:0] pc_target_i = 13'h0000, fetch_addr_o;
  logic [15:0] instr_o, q, pm [8192];
  logic [7:0] tab_low_byte_o, table_high_byte_latch_o, hb;
  logic tab_busy_o, tab_done_o, prog_enable_i, prog_serial_clock_i, prog_serial_data_o;
  logic prog_serial_data_oe_o, shared_func_en_o, core_hold_o;
  pmt_tab_req_t tab_req_i = '0;
  int miscompares = 0, n_compared = 0, n;
  integer seed = 32'he95846b2;
  wire logic prog_serial_data_i = prog_serial_data_oe_o ? prog_serial_data_o : s_d;
  pmt_program_memory uut (.sys_clk_i, .rst_n_i, .ce_i, .pc_load_i, .pc_target_i, .pc_step_i,
    .fetch_addr_o, .instr_o, .tab_start_i, .tab_req_i, .tab_busy_o, .tab_done_o,
    .tab_low_byte_o, .table_high_byte_latch_o, .debug_mode_i, .prog_enable_i,
    .prog_serial_clock_i, .prog_serial_data_i, .prog_serial_data_o, .prog_serial_data_oe_o,
    .shared_func_en_o, .core_hold_o);
  pmt_prog_model prog (.ck_o(prog_serial_clock_i), .en_o(prog_enable_i), .d_o(s_d),
    .pin_i(prog_serial_data_i));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic tick(int k = 1);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic wr(logic [12:0] a);
    pm[a] = 16'($random(seed));
    prog.xfer({2'b00, a, pm[a]}, q);
  endtask : wr
  // Start is held into the busy cycle, where it must be ignored
  task automatic tab(logic lp, logic [7:0] hp, logic [7:0] lo);
    logic [12:0] a;
    a = {lp ? 5'h1f : hp[4:0], lo};
    tab_req_i = {lp, hp, lo};
    tab_start_i = 1'b1;
    tick(2);
    tab_start_i = 1'b0;
    `CHK(tab_busy_o, 1'b1)
    for (n = 2; n < 9 && tab_done_o !== 1'b1; n++) tick();
    `CHK(n, 3)
    `CHK(tab_busy_o, 1'b0)
    `CHK(tab_low_byte_o, pm[a][7:0])
    `CHK(table_high_byte_latch_o, pm[a][15:8])
  endtask : tab
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    tick(12);
    rst_n_i = 1'b1;
    `CHK(fetch_addr_o, 13'h0000)
    `CHK(shared_func_en_o, 1'b1)
    foreach (ADR[i]) wr(ADR[i]);
    prog.xfer({2'b01, 13'h002a, 16'h005c}, q);
    prog.xfer({2'b11, 13'h002a, 16'h0000}, q);
    `CHK(q[7:0], 8'h5c)
    debug_mode_i = 1'b1;
    prog.xfer({2'b10, 13'h1f06, 16'h0000}, q);
    `CHK(q, pm[13'h1f06])
    `CHK(shared_func_en_o, 1'b0)
    debug_mode_i = 1'b0;
    tick(8);
    `CHK(shared_func_en_o, 1'b1)
    `CHK(core_hold_o, 1'b0)
    `CHK(prog_serial_data_oe_o, 1'b0)
    $display("link test done");
    tab(1'b1, 8'h03, 8'h06);
    tab(1'b0, 8'h1f, 8'h05);
    tab(1'b0, 8'he1, 8'h05);
    hb = pm[13'h0105][15:8];
    wr(13'h0105);
    `CHK(table_high_byte_latch_o, hb)
    tab(1'b0, 8'h01, 8'h05);
    $display("table test done");
    pc_target_i = 13'h0123;
    pc_load_i = 1'b1;
    tick();
    pc_load_i = 1'b0;
    `CHK(fetch_addr_o, 13'h0123)
    `CHK(instr_o, pm[13'h0123])
    pc_step_i = 1'b1;
    tick();
    pc_step_i = 1'b0;
    `CHK(instr_o, pm[13'h0124])
    ce_i = 1'b0;
    pc_step_i = 1'b1;
    tick(3);
    `CHK(fetch_addr_o, 13'h0124)
    ce_i = 1'b1;
    tick();
    pc_step_i = 1'b0;
    `CHK(fetch_addr_o, 13'h0125)
    rst_n_i = 1'b0;
    tick();
    `CHK(table_high_byte_latch_o, 8'h00)
    rst_n_i = 1'b1;
    tick(2);
    `CHK(fetch_addr_o, 13'h0000)
    `CHK(instr_o, pm[0])
    $display("fetch test done");
    print_verdict();
  end
endmodule : program_memory_table_read_test
`default_nettype wire
